// ---- pkg/dmrp_pkg.sv ----
package dmrp_pkg;

  // ----------------------------------------------------------------
  // Mode register image layout
  // ----------------------------------------------------------------
  localparam int MR_W = 22;
  localparam int MR_SEL_HI = 20;
  localparam int MR_SEL_LO = 18;
  localparam int MR_RSV_HI = 21;
  localparam int MR_RSV_MID = 17;
  localparam int MR_WR_HI = 13;
  localparam int MR_WR_LO_HI = 11;
  localparam int MR_WR_LO_LO = 9;
  localparam int MR_DLL_RST = 8;
  localparam int MR_COUNT = 7;
  localparam logic [2:0] MR_SEL_UNUSED = 3'h7;
  localparam logic [MR_W-1:0] MR_RST_VAL = 22'h000000;
  localparam logic [4:0] WR_RST_VAL = 5'h0a;
  localparam logic [3:0] RTP_RST_VAL = 4'h5;
  localparam logic [3:0] WR_CODE_MAX = 4'h8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_MIN_NS = 100;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    DMRP_CMD_DES = 2'b00,
    DMRP_CMD_MRS = 2'b01,
    DMRP_CMD_OTHER = 2'b10
  } dmrp_cmd_e;

  // Command pins sampled on the link clock
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic a17;
    logic [13:0] a;
  } dmrp_pins_s;

  typedef struct packed {
    logic [4:0] wr_clk;
    logic [3:0] rtp_clk;
    logic wr_valid;
  } dmrp_wr_s;

endpackage

// ---- rtl/dmrp_sync.sv ----
`timescale 1ns/100ps
module dmrp_sync
  import dmrp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic s1;
    logic s2;
  } dmrp_sync_s;

  dmrp_sync_s st_ff;
  dmrp_sync_s nxt_st;

  always_comb begin
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.s2;

endmodule

// ---- rtl/dmrp_top.sv ----
`timescale 1ns/100ps
module dmrp_top
  import dmrp_pkg::*;
#(
  parameter int NUM_MR = MR_COUNT
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ck_clk,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic a17,
  input wire logic [13:0] a,
  output logic [MR_W-1:0] mode_register_zero,
  output logic [4:0] wr_clocks,
  output logic [3:0] rtp_clocks,
  output logic wr_code_valid,
  output logic dll_reset_req,
  output logic [NUM_MR-1:0] mr_written,
  output logic all_mr_written,
  output logic ready
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Rebuild the register image from the address pins
  function automatic logic [MR_W-1:0] pins_to_image(input dmrp_pins_s p);
    logic [MR_W-1:0] img;
    img = '0;
    img[21:20] = p.bg;
    img[19:18] = p.ba;
    img[17] = p.a17;
    img[13:0] = p.a;
    return img;
  endfunction

  function automatic dmrp_wr_s wr_decode(input logic [3:0] code);
    dmrp_wr_s d;
    d.wr_valid = 1'b1;
    d.rtp_clk = RTP_RST_VAL;
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
        d.rtp_clk = RTP_RST_VAL + code;
      end
      4'h6: begin
        d.rtp_clk = 4'hc;
      end
      4'h7: begin
        d.rtp_clk = 4'hb;
      end
      4'h8: begin
        d.rtp_clk = 4'hd;
      end
      default: begin
        d.wr_valid = 1'b0;
      end
    endcase
    d.wr_clk = {d.rtp_clk, 1'b0};
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Link domain: capture of mode register set commands
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [MR_W-1:0] img;
    logic [2:0] sel;
    logic tgl;
  } dmrp_link_s;

  dmrp_link_s lk_ff;
  dmrp_link_s nxt_lk;
  logic lk_rst_m_ff;
  logic lk_rstn_ff;
  dmrp_pins_s pins;
  dmrp_cmd_e cmd;

  always_comb begin
    pins.cs_n = cs_n;
    pins.ras_n = ras_n;
    pins.cas_n = cas_n;
    pins.we_n = we_n;
    pins.bg = bg;
    pins.ba = ba;
    pins.a17 = a17;
    pins.a = a;
    if (!cke || cs_n) begin
      cmd = DMRP_CMD_DES;
    end else if (!ras_n && !cas_n && !we_n) begin
      cmd = DMRP_CMD_MRS;
    end else begin
      cmd = DMRP_CMD_OTHER;
    end
  end

  // Reset for the link domain, released on the link clock
  always_ff @(posedge ck_clk) begin
    lk_rst_m_ff <= rstn;
    lk_rstn_ff <= lk_rst_m_ff;
  end

  always_comb begin
    nxt_lk = lk_ff;
    if (cmd == DMRP_CMD_MRS) begin
      nxt_lk.img = pins_to_image(pins);
      nxt_lk.sel = nxt_lk.img[MR_SEL_HI:MR_SEL_LO];
      nxt_lk.tgl = ~lk_ff.tgl;
    end
  end

  always_ff @(posedge ck_clk) begin
    if (!lk_rstn_ff) begin
      lk_ff <= '0;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  logic tgl_sync;

  dmrp_sync u_tgl_sync (
    .clk(sys_clk),
    .rstn(rstn),
    .din(lk_ff.tgl),
    .dout(tgl_sync)
  );

  // ----------------------------------------------------------------
  // System domain: register bank and reset bookkeeping
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tgl_seen;
    logic [MR_W-1:0] mr0;
    dmrp_wr_s wr;
    logic dll_rst;
    logic [NUM_MR-1:0] written;
    logic all;
    logic rdy;
  } dmrp_sys_s;

  dmrp_sys_s st_ff;
  dmrp_sys_s nxt_st;
  logic [2:0] sel_c;

  always_comb begin
    nxt_st = st_ff;
    sel_c = lk_ff.sel;
    nxt_st.tgl_seen = tgl_sync;
    nxt_st.dll_rst = 1'b0;
    // Image is stable in the link domain when the toggle arrives
    if (tgl_sync != st_ff.tgl_seen) begin
      if (sel_c != MR_SEL_UNUSED && int'(sel_c) < NUM_MR) begin
        nxt_st.written[sel_c] = 1'b1;
        if (sel_c == 3'h0) begin
          nxt_st.mr0 = lk_ff.img;
          nxt_st.wr = wr_decode({lk_ff.img[MR_WR_HI],
                                 lk_ff.img[MR_WR_LO_HI:MR_WR_LO_LO]});
          // Self-clearing: reported as a one-cycle pulse; the bit still stays in mode_register_zero
          nxt_st.dll_rst = lk_ff.img[MR_DLL_RST];
        end
      end
    end
    nxt_st.all = &nxt_st.written;
    nxt_st.rdy = &st_ff.written;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_ff.tgl_seen <= 1'b0;
      st_ff.mr0 <= MR_RST_VAL;
      st_ff.wr.wr_clk <= WR_RST_VAL;
      st_ff.wr.rtp_clk <= RTP_RST_VAL;
      st_ff.wr.wr_valid <= 1'b0;
      st_ff.dll_rst <= 1'b0;
      st_ff.written <= '0;
      st_ff.all <= 1'b0;
      st_ff.rdy <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign mode_register_zero = st_ff.mr0;
  assign wr_clocks = st_ff.wr.wr_clk;
  assign rtp_clocks = st_ff.wr.rtp_clk;
  assign wr_code_valid = st_ff.wr.wr_valid;
  assign dll_reset_req = st_ff.dll_rst;
  assign mr_written = st_ff.written;
  assign all_mr_written = st_ff.all;
  assign ready = st_ff.rdy;

endmodule

// ---- tb/dmrp_props.sv ----
`timescale 1ns/100ps
module dmrp_props
  import dmrp_pkg::*;
#(
  parameter int NUM_MR = MR_COUNT
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [MR_W-1:0] mode_register_zero,
  input wire logic [4:0] wr_clocks,
  input wire logic [3:0] rtp_clocks,
  input wire logic wr_code_valid,
  input wire logic dll_reset_req,
  input wire logic [NUM_MR-1:0] mr_written,
  input wire logic all_mr_written
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  logic [3:0] c;
  logic [3:0] r;
  assign c = {mode_register_zero[MR_WR_HI], mode_register_zero[MR_WR_LO_HI:MR_WR_LO_LO]};
  assign r = c < 4'h6 ? c + 4'h5 : (c == 4'h6 ? 4'hc : (c == 4'h7 ? 4'hb : 4'hd));
  sequence s_pulse;
    mode_register_zero[MR_DLL_RST] ##1 !dll_reset_req;
  endsequence
  a_rst_vals: assert property ($rose(rstn) |->
    mr_written == '0 && wr_clocks == WR_RST_VAL)
    else $error("outputs not cleared by reset");
  a_all_written: assert property (all_mr_written == &mr_written)
    else $error("all-written flag wrong");
  a_mask_sticky: assert property (
    (mr_written & $past(mr_written)) == $past(mr_written))
    else $error("written bit dropped");
  a_sel_fixed: assert property (mode_register_zero[MR_SEL_HI:14] == '0)
    else $error("stored select or gap bits nonzero");
  a_wr_valid: assert property (mode_register_zero != '0 |->
    wr_code_valid == (c <= WR_CODE_MAX))
    else $error("code valid flag wrong");
  a_wr_map: assert property (wr_code_valid |->
    rtp_clocks == r && wr_clocks == {r, 1'b0})
    else $error("recovery decode wrong");
  a_dll_pulse: assert property (dll_reset_req |-> s_pulse)
    else $error("dll reset pulse wrong");
  a_mr0_marks: assert property ($changed(mode_register_zero) |-> mr_written[0])
    else $error("image changed without mark");
endmodule
bind dmrp_top dmrp_props #(.NUM_MR(NUM_MR)) dmrp_props_inst (.sys_clk(sys_clk), .rstn(rstn),
  .mode_register_zero(mode_register_zero), .wr_clocks(wr_clocks), .rtp_clocks(rtp_clocks),
  .wr_code_valid(wr_code_valid), .dll_reset_req(dll_reset_req), .mr_written(mr_written),
  .all_mr_written(all_mr_written));

// ---- tb/dmrp_ctrl.sv ----
`timescale 1ns/100ps
module dmrp_ctrl
  import dmrp_pkg::*;
#(
  parameter int MRD_CYC = 5
)
(
  input wire logic ck_clk,
  output logic cke,
  output dmrp_pins_s pins
);
  dmrp_pins_s q;
  // Termination level; the device has no termination pin, so it stays low
  logic odt;
  initial begin
    cke = 1'b0;
    odt = 1'b0;
    pins = '1;
  end
  task automatic set_cke(input logic v);
    @(posedge ck_clk);
    cke <= v;
  endtask
  // Kind 0 mode write, 1 other command, 2 mode write with cke low
  task automatic send(input logic [MR_W-1:0] img, input int kind);
    q = {1'b0, kind == 1, 2'b00, img[21:17], img[13:0]};
    @(posedge ck_clk);
    cke <= (kind != 2);
    odt <= 1'b0;
    pins <= q;
    q = ~q;
    q.cs_n = 1'b1;
    @(posedge ck_clk);
    cke <= 1'b1;
    pins <= q;
    repeat (MRD_CYC) @(posedge ck_clk);
  endtask
endmodule

// ---- tb/dmrp_top_bench.sv ----
`timescale 1ns/100ps
module dmrp_top_bench;
  import dmrp_pkg::*;
  logic sys_clk = 1'b0;
  logic ck_clk = 1'b0;
  logic rstn = 1'b0;
  logic cke, wv, dll, allw, rdy;
  dmrp_pins_s p;
  logic [MR_W-1:0] mr0;
  logic [4:0] wrc;
  logic [3:0] rtpc;
  logic [MR_COUNT-1:0] mw;
  int err_total = 0;
  int num_checks = 0;
  int pulses = 0;
  int e_pul = 0;
  int e_rtp = 5;
  logic [MR_W-1:0] e_mr0 = '0;
  logic [MR_COUNT-1:0] e_mw = '0;
  logic e_v = 1'b0;
  always #5 sys_clk = ~sys_clk;
  always #16 ck_clk = ~ck_clk;
  always @(posedge sys_clk) begin
    if (dll === 1'b1) pulses <= pulses + 1;
  end
  dmrp_top dmrp_top_inst (.sys_clk(sys_clk), .rstn(rstn), .ck_clk(ck_clk), .cke(cke),
    .cs_n(p.cs_n), .ras_n(p.ras_n), .cas_n(p.cas_n), .we_n(p.we_n), .bg(p.bg), .ba(p.ba),
    .a17(p.a17), .a(p.a), .mode_register_zero(mr0), .wr_clocks(wrc), .rtp_clocks(rtpc),
    .wr_code_valid(wv), .dll_reset_req(dll), .mr_written(mw), .all_mr_written(allw),
    .ready(rdy));
  dmrp_ctrl dmrp_ctrl_inst (.ck_clk(ck_clk), .cke(cke), .pins(p));
  // ----------------------------------------
  // Compare and sequencing tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check_all();
    @(negedge sys_clk);
    chk(mr0, e_mr0);
    chk(mw, e_mw);
    chk({allw, rdy}, {2{&e_mw}});
    chk(wv, e_v);
    if (e_v || !e_mw[0]) chk({wrc, rtpc}, {5'(2 * e_rtp), 4'(e_rtp)});
    chk(pulses, e_pul);
  endtask
  task automatic do_reset();
    dmrp_ctrl_inst.set_cke(1'b0);
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    e_mr0 = '0;
    e_mw = '0;
    e_v = 1'b0;
    e_rtp = 5;
    repeat (12) @(posedge sys_clk);
    check_all();
    dmrp_ctrl_inst.set_cke(1'b1);
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic cmd(input logic [MR_W-1:0] img, input int kind);
    int c;
    dmrp_ctrl_inst.send(img, kind);
    c = {img[13], img[11:9]};
    if (kind == 0 && img[20:18] != MR_SEL_UNUSED) begin
      e_mw[img[20:18]] = 1'b1;
      if (img[20:18] == 3'h0) begin
        e_mr0 = img;
        e_pul += img[8];
        e_v = c <= 8;
        if (e_v) e_rtp = c < 6 ? 5 + c : (c == 6 ? 12 : (c == 7 ? 11 : 13));
      end
    end
    check_all();
  endtask
  initial begin
    logic [MR_W-1:0] img;
    int sel;
    void'($urandom(32'h40021d08));
    do_reset();
    for (int k = 0; k < 40; k++) begin
      img = 22'($urandom) & 22'h1c3fff;
      sel = k < 7 ? 6 - k : (k < 23 ? 0 : $urandom_range(7, 0));
      if (k >= 7 && k < 23) {img[13], img[11:9]} = 4'(k - 7);
      img[20:18] = 3'(sel);
      cmd(img, k < 30 ? 0 : k % 3);
      if (k == 34) do_reset();
    end
    cmd(22'h1c0000, 0);
    cmd(22'h040001, 0);
    cmd(22'h000100, 0);
    final_report();
  end
  initial begin
    #50000;
    err_total++;
    final_report();
  end
endmodule
